//--- lsw_top.sv
// Purpose: Limit switch enable control with AXI4-Lite register access
// Assumes: Power state and sequencer slot ticks come from the power sequencer
// Notes: Summary of operation follows
// Summary of operation
// - Active state: switch follows enable request bit
// - Pre-active request waits until active state
// - Start-up slot code sets enable at slot
// - Shutdown slot clears enable; so does entering off state, unless a start-up slot event sets it that cycle
// - Custom modes substitute preset start-up slot
// - Hibernate opens switch unless keep bit set
// - Enable bit shared at two addresses
// - Enable is request; actual state in status
// - Bulk detection on while switch closed
// - Active, switch off: bulk follows active bit
// - Hibernate, switch off: bulk follows hibernate bit
//
// The AXI4-Lite slave port was left to the implementer.
`timescale 1ns/10ps
`default_nettype none
module lsw_top
    import lsw_pkg::*;
#(
    parameter logic [3:0] CUSTOM_START_SLOT = 4'h1
)(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Power sequencer
    input wire lsw_pstate_e pstate,
    input wire lsw_seq_s seq,
    input wire logic dev_mode,
    // Switch drive
    output logic switch_closed,
    output logic bulk_detect_on,
    // AXI4-Lite write address
    input wire logic [31:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    // AXI4-Lite write data
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    // AXI4-Lite read address
    input wire logic [31:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    logic enable_r;
    logic [3:0] start_slot_r;
    logic [3:0] shut_slot_r;
    logic hib_keep_r;
    logic hib_prot_r;
    logic act_prot_r;
    logic [3:0] last_start_r;
    logic [3:0] last_shut_r;
    lsw_pstate_e prev_ps_r;
    logic [31:0] awaddr_r;
    logic aw_held_r;
    logic [31:0] wdata_r;
    logic [3:0] wstrb_r;
    logic w_held_r;
    lsw_drive_s drive;

    logic [3:0] start_eff;
    logic [7:0] aw_idx;
    logic [7:0] ar_idx;
    logic wr_fire;
    logic wr_hit;
    logic wr_enable;
    logic wr_ctrl;
    logic start_evt;
    logic shut_evt;
    logic enter_active;
    logic enter_off;
    logic [15:0] ctrl_view;
    logic [31:0] rd_val;
    logic rd_hit;

    // Custom modes use the preset slot
    assign start_eff = dev_mode ? start_slot_r : CUSTOM_START_SLOT;

    assign aw_idx = awaddr_r[9:2];
    assign ar_idx = s_axi_araddr[9:2];
    assign wr_fire = aw_held_r & w_held_r & ~s_axi_bvalid;
    assign wr_enable = wr_fire & wstrb_r[1]
        & (aw_idx == LSW_IDX_SUPPLY_CTRL || aw_idx == LSW_IDX_SUPPLY_REQ);
    assign wr_ctrl = wr_fire & (aw_idx == LSW_IDX_SWITCH_CTRL);
    assign wr_hit = (aw_idx == LSW_IDX_SUPPLY_CTRL) || (aw_idx == LSW_IDX_SUPPLY_REQ)
        || (aw_idx == LSW_IDX_SWITCH_CTRL) || (aw_idx == LSW_IDX_SWITCH_STAT)
        || (aw_idx == LSW_IDX_SLOT_EVENT);

    // Sequencer slot events
    assign enter_active = (pstate == LSW_PS_ACTIVE) && (prev_ps_r != LSW_PS_ACTIVE);
    assign enter_off = (pstate == LSW_PS_OFF) && (prev_ps_r != LSW_PS_OFF);
    always_comb begin
        start_evt = 1'b0;
        if (start_eff == LSW_SLOT_ACTIVE) begin
            start_evt = enter_active;
        end else if (start_eff != LSW_SLOT_NONE) begin
            start_evt = seq.startup_tick && (seq.slot == start_eff);
        end
    end
    always_comb begin
        shut_evt = enter_off;
        if (shut_slot_r != LSW_SLOT_NONE && shut_slot_r != LSW_SLOT_ACTIVE) begin
            shut_evt = enter_off || (seq.shutdown_tick && (seq.slot == shut_slot_r));
        end
    end

    // Shared enable request bit, sequencer set wins over clears
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            enable_r <= LSW_RST_ENABLE;
        end else if (start_evt) begin
            enable_r <= 1'b1;
        end else if (shut_evt) begin
            enable_r <= 1'b0;
        end else if (wr_enable) begin
            enable_r <= wdata_r[LSW_BIT_ENABLE];
        end
    end

    // Switch control fields
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            start_slot_r <= LSW_RST_START;
            shut_slot_r <= LSW_RST_SHUT;
            hib_keep_r <= LSW_RST_HIB_KEEP;
            hib_prot_r <= LSW_RST_HIB_PROT;
            act_prot_r <= LSW_RST_ACT_PROT;
        end else if (wr_ctrl) begin
            if (wstrb_r[1]) begin
                start_slot_r <= wdata_r[LSW_BIT_START_HI:LSW_BIT_START_LO];
                shut_slot_r[3:2] <= wdata_r[LSW_BIT_SHUT_HI:8];
            end
            if (wstrb_r[0]) begin
                shut_slot_r[1:0] <= wdata_r[7:LSW_BIT_SHUT_LO];
                hib_keep_r <= wdata_r[LSW_BIT_HIB_KEEP];
                hib_prot_r <= wdata_r[LSW_BIT_HIB_PROT];
                act_prot_r <= wdata_r[LSW_BIT_ACT_PROT];
            end
        end
    end

    // Power state history and last seen slots
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            prev_ps_r <= LSW_PS_OFF;
            last_start_r <= 4'h0;
            last_shut_r <= 4'h0;
        end else begin
            prev_ps_r <= pstate;
            if (seq.startup_tick) begin
                last_start_r <= seq.slot;
            end
            if (seq.shutdown_tick) begin
                last_shut_r <= seq.slot;
            end
        end
    end

    lsw_switch_logic u_logic (
        .clk(clk),
        .arst_n(arst_n),
        .pstate(pstate),
        .enable_req(enable_r),
        .hib_keep(hib_keep_r),
        .act_prot(act_prot_r),
        .hib_prot(hib_prot_r),
        .drive(drive)
    );
    assign switch_closed = drive.switch_closed;
    assign bulk_detect_on = drive.bulk_detect_on;

    // Write channel capture
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            awaddr_r <= 32'h0000_0000;
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end else if (s_axi_awvalid && s_axi_awready) begin
            awaddr_r <= s_axi_awaddr;
            aw_held_r <= 1'b1;
            s_axi_awready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            aw_held_r <= 1'b0;
            s_axi_awready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            wdata_r <= 32'h0000_0000;
            wstrb_r <= 4'h0;
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end else if (s_axi_wvalid && s_axi_wready) begin
            wdata_r <= s_axi_wdata;
            wstrb_r <= s_axi_wstrb;
            w_held_r <= 1'b1;
            s_axi_wready <= 1'b0;
        end else if (s_axi_bvalid && s_axi_bready) begin
            w_held_r <= 1'b0;
            s_axi_wready <= 1'b1;
        end
    end

    // Write response
    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= LSW_RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? LSW_RESP_OKAY : LSW_RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Read decode
    assign ctrl_view = {2'b00, start_slot_r, shut_slot_r, 1'b0, hib_keep_r,
        2'b00, hib_prot_r, act_prot_r};
    always_comb begin
        rd_val = 32'h0000_0000;
        rd_hit = 1'b1;
        unique case (ar_idx)
            LSW_IDX_SUPPLY_CTRL, LSW_IDX_SUPPLY_REQ: rd_val[LSW_BIT_ENABLE] = enable_r;
            LSW_IDX_SWITCH_CTRL: rd_val[15:0] = ctrl_view;
            LSW_IDX_SWITCH_STAT: rd_val[1:0] = {drive.bulk_detect_on, drive.switch_closed};
            LSW_IDX_SLOT_EVENT: rd_val[7:0] = {last_shut_r, last_start_r};
            default: rd_hit = 1'b0;
        endcase
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= LSW_RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_val;
            s_axi_rresp <= rd_hit ? LSW_RESP_OKAY : LSW_RESP_SLVERR;
        end else if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end
endmodule // lsw_top
`default_nettype wire

//--- lsw_pkg.sv
// Purpose: Shared constants and types for the limit switch enable control block
// Assumes: AXI4-Lite register access, 32-bit data, one word per register
// Notes: Register byte address is four times the printed register index
package lsw_pkg;

    // Register indices as printed, byte address is index times four
    localparam logic [7:0] LSW_IDX_SUPPLY_CTRL = 8'h0D;
    localparam logic [7:0] LSW_IDX_SUPPLY_REQ = 8'hB0;
    localparam logic [7:0] LSW_IDX_SWITCH_CTRL = 8'hC7;
    localparam logic [7:0] LSW_IDX_SWITCH_STAT = 8'hC8;
    localparam logic [7:0] LSW_IDX_SLOT_EVENT = 8'hC9;

    // Field positions
    localparam int LSW_BIT_ENABLE = 15;
    localparam int LSW_BIT_START_HI = 13;
    localparam int LSW_BIT_START_LO = 10;
    localparam int LSW_BIT_SHUT_HI = 9;
    localparam int LSW_BIT_SHUT_LO = 6;
    localparam int LSW_BIT_HIB_KEEP = 4;
    localparam int LSW_BIT_HIB_PROT = 1;
    localparam int LSW_BIT_ACT_PROT = 0;

    // Slot codes
    localparam logic [3:0] LSW_SLOT_NONE = 4'h0;
    localparam logic [3:0] LSW_SLOT_ACTIVE = 4'hF;

    // Reset values
    localparam logic LSW_RST_ENABLE = 1'b0;
    localparam logic [3:0] LSW_RST_START = 4'h0;
    localparam logic [3:0] LSW_RST_SHUT = 4'h0;
    localparam logic LSW_RST_HIB_KEEP = 1'b0;
    localparam logic LSW_RST_HIB_PROT = 1'b1;
    localparam logic LSW_RST_ACT_PROT = 1'b1;

    localparam logic [1:0] LSW_RESP_OKAY = 2'h0;
    localparam logic [1:0] LSW_RESP_SLVERR = 2'h2;

    // Power states reported by the surrounding power state machine
    typedef enum logic [2:0] {
        LSW_PS_OFF,
        LSW_PS_STARTUP,
        LSW_PS_PREACTIVE,
        LSW_PS_ACTIVE,
        LSW_PS_HIBERNATE,
        LSW_PS_SHUTDOWN,
        LSW_PS_LOWPOWER
    } lsw_pstate_e;

    // Sequencer event carrier
    typedef struct packed {
        logic startup_tick;
        logic shutdown_tick;
        logic [3:0] slot;
    } lsw_seq_s;

    // Switch outputs carrier
    typedef struct packed {
        logic switch_closed;
        logic bulk_detect_on;
    } lsw_drive_s;

endpackage

//--- lsw_switch_logic.sv
// Purpose: Effective switch and bulk detection decision from state and settings
// Assumes: Inputs synchronous to clk
// Notes: Outputs are registered
`timescale 1ns/10ps
`default_nettype none
module lsw_switch_logic
    import lsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // Power state and settings
    input wire lsw_pstate_e pstate,
    input wire logic enable_req,
    input wire logic hib_keep,
    input wire logic act_prot,
    input wire logic hib_prot,
    // Decision
    output lsw_drive_s drive
);
    logic closed_nxt;
    logic bulk_nxt;

    always_comb begin
        closed_nxt = 1'b0;
        unique case (pstate)
            LSW_PS_ACTIVE: closed_nxt = enable_req;
            LSW_PS_HIBERNATE: closed_nxt = enable_req & hib_keep;
            LSW_PS_SHUTDOWN: closed_nxt = enable_req;
            LSW_PS_STARTUP: closed_nxt = enable_req;
            LSW_PS_OFF, LSW_PS_PREACTIVE, LSW_PS_LOWPOWER: closed_nxt = 1'b0;
            default: closed_nxt = 1'b0;
        endcase
    end

    always_comb begin
        bulk_nxt = 1'b0;
        if (closed_nxt) begin
            bulk_nxt = 1'b1;
        end else if (pstate == LSW_PS_ACTIVE) begin
            bulk_nxt = act_prot;
        end else if (pstate == LSW_PS_HIBERNATE) begin
            bulk_nxt = hib_prot;
        end
    end

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            drive <= '0;
        end else begin
            drive.switch_closed <= closed_nxt;
            drive.bulk_detect_on <= bulk_nxt;
        end
    end
endmodule // lsw_switch_logic
`default_nettype wire

//--- lsw_top_checker.sv
// Purpose: Port-level checks for the limit switch enable control
// Assumes: One clock domain, bound to lsw_top
// Notes: Register fields are internal, so checks tie outputs to state and bus
`timescale 1ns/10ps
`default_nettype none
module lsw_top_checker
    import lsw_pkg::*;
(
    // Clock and reset
    input wire logic clk,
    input wire logic arst_n,
    // State and drive
    input wire lsw_pstate_e pstate,
    input wire logic switch_closed,
    input wire logic bulk_detect_on,
    // Register bus
    input wire logic s_axi_awvalid,
    input wire logic s_axi_awready,
    input wire logic s_axi_wvalid,
    input wire logic s_axi_wready,
    input wire logic [1:0] s_axi_bresp,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready
);
    default clocking @(posedge clk); endclocking
    default disable iff (!arst_n);
    off_open_a: assert property (pstate inside {LSW_PS_OFF, LSW_PS_LOWPOWER} |=> !switch_closed)
        else $error("switch closed in off or low power");
    preact_open_a: assert property (pstate == LSW_PS_PREACTIVE |=> !switch_closed)
        else $error("switch closed in pre-active");
    bulk_closed_a: assert property (switch_closed |-> bulk_detect_on)
        else $error("bulk detect off while switch closed");
    bulk_idle_a: assert property (!(pstate inside {LSW_PS_ACTIVE, LSW_PS_HIBERNATE})
        |=> bulk_detect_on == switch_closed)
        else $error("bulk detect on outside active and hibernate");
    wr_answer_a: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
        |-> ##2 s_axi_bvalid)
        else $error("write answer late");
    rd_answer_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read answer late");
    b_hold_a: assert property (s_axi_bvalid && !s_axi_bready
        |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    r_hold_a: assert property (s_axi_rvalid && !s_axi_rready
        |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while answer pending");
endmodule // lsw_top_checker

bind lsw_top lsw_top_checker lsw_top_checker_i (.clk, .arst_n, .pstate, .switch_closed,
    .bulk_detect_on, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
    .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rvalid,
    .s_axi_rready);
`default_nettype wire

//--- lsw_top_tb.sv
// Purpose: Self-checking bench for the limit switch enable control
// Assumes: AXI4-Lite master tasks, byte address is index times four
// Notes: Power state and sequencer ticks are driven directly
`timescale 1ns/10ps
`default_nettype none
module lsw_top_tb
    import lsw_pkg::*;
;
    localparam logic [31:0] A_EN = 32'(LSW_IDX_SUPPLY_CTRL) << 2;
    localparam logic [31:0] A_RQ = 32'(LSW_IDX_SUPPLY_REQ) << 2;
    localparam logic [31:0] A_CT = 32'(LSW_IDX_SWITCH_CTRL) << 2;
    localparam logic [31:0] A_ST = 32'(LSW_IDX_SWITCH_STAT) << 2;
    localparam logic [31:0] A_SE = 32'(LSW_IDX_SLOT_EVENT) << 2;
    localparam logic [1:0] OK = LSW_RESP_OKAY;
    logic clk = 1'b0;
    logic arst_n = 1'b0;
    lsw_pstate_e pstate = LSW_PS_OFF;
    lsw_seq_s seq = '0;
    logic dev_mode = 1'b1;
    logic switch_closed, bulk_detect_on, s_axi_awready, s_axi_wready, s_axi_bvalid;
    logic s_axi_arready, s_axi_rvalid;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [31:0] s_axi_awaddr = '0, s_axi_wdata = '0, s_axi_araddr = '0, s_axi_rdata;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
    logic s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
    int fail_count = 0, n_compared = 0, cyc = 0;

    lsw_top lsw_top_i (.clk, .arst_n, .pstate, .seq, .dev_mode, .switch_closed, .bulk_detect_on,
        .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
        .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready);

    always #25 clk = ~clk;

    task automatic close_out();
        $display("Compared %0d, mismatches %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            fail_count++;
            $display("Error at %0t: timeout", $time);
            close_out();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            fail_count++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [1:0] r);
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wready) s_axi_wvalid <= 1'b0;
            s_axi_bready <= s_axi_bvalid && !s_axi_bready;
        end while (!(s_axi_bvalid && s_axi_bready));
        chk(32'(s_axi_bresp), 32'(r));
    endtask

    task automatic rd(input logic [31:0] a, input logic [31:0] e, input logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        do begin
            @(posedge clk);
            if (s_axi_arready) s_axi_arvalid <= 1'b0;
            s_axi_rready <= s_axi_rvalid && !s_axi_rready;
        end while (!(s_axi_rvalid && s_axi_rready));
        chk(s_axi_rdata, e);
        chk(32'(s_axi_rresp), 32'(r));
    endtask

    task automatic pins(input logic c, input logic b);
        repeat (2) @(posedge clk);
        chk({30'h0, switch_closed, bulk_detect_on}, {30'h0, c, b});
    endtask

    task automatic go(input lsw_pstate_e p);
        @(posedge clk);
        pstate <= p;
    endtask

    task automatic tick(input logic st, input logic [3:0] s);
        @(posedge clk);
        seq <= '{st, !st, s};
        @(posedge clk);
        seq <= '0;
    endtask

    initial begin
        repeat (16) @(posedge clk);
        arst_n <= 1'b1;
        rd(A_EN, 32'h0, OK);
        rd(A_CT, 32'h3, OK);
        go(LSW_PS_PREACTIVE);
        wr(A_EN, 32'h8000, OK);
        pins(1'b0, 1'b0);
        rd(A_RQ, 32'h8000, OK);
        go(LSW_PS_ACTIVE);
        pins(1'b1, 1'b1);
        rd(A_ST, 32'h3, OK);
        wr(A_RQ, 32'h0, OK);
        pins(1'b0, 1'b1);
        rd(A_EN, 32'h0, OK);
        wr(A_CT, 32'h2, OK);
        pins(1'b0, 1'b0);
        wr(A_EN, 32'h8000, OK);
        go(LSW_PS_HIBERNATE);
        pins(1'b0, 1'b1);
        wr(A_CT, 32'h10, OK);
        pins(1'b1, 1'b1);
        wr(A_RQ, 32'h0, OK);
        pins(1'b0, 1'b0);
        go(LSW_PS_ACTIVE);
        for (int s = 1; s < 15; s++) begin
            wr(A_CT, (32'(s) << 10) | (32'(s) << 6), OK);
            tick(1'b1, 4'(15 - s));
            rd(A_EN, 32'h0, OK);
            tick(1'b1, 4'(s));
            rd(A_EN, 32'h8000, OK);
            tick(1'b0, 4'(15 - s));
            rd(A_EN, 32'h8000, OK);
            tick(1'b0, 4'(s));
            rd(A_EN, 32'h0, OK);
        end
        @(posedge clk) dev_mode <= 1'b0;
        wr(A_CT, 32'h1400, OK);
        tick(1'b1, 4'h5);
        rd(A_EN, 32'h0, OK);
        tick(1'b1, 4'h1);
        rd(A_EN, 32'h8000, OK);
        rd(A_SE, 32'hE1, OK);
        @(posedge clk) dev_mode <= 1'b1;
        go(LSW_PS_PREACTIVE);
        wr(A_CT, 32'h3C00, OK);
        wr(A_EN, 32'h0, OK);
        go(LSW_PS_ACTIVE);
        rd(A_EN, 32'h8000, OK);
        go(LSW_PS_OFF);
        pins(1'b0, 1'b0);
        rd(A_EN, 32'h0, OK);
        wr(A_EN, 32'h8000, OK);
        go(LSW_PS_LOWPOWER);
        pins(1'b0, 1'b0);
        go(LSW_PS_STARTUP);
        pins(1'b1, 1'b1);
        go(LSW_PS_SHUTDOWN);
        pins(1'b1, 1'b1);
        wr(32'h100, 32'hFFFF, LSW_RESP_SLVERR);
        rd(32'h100, 32'h0, LSW_RESP_SLVERR);
        wr(A_CT, 32'h3, OK);
        rd(A_CT, 32'h3, OK);
        close_out();
    end
endmodule // lsw_top_tb
`default_nettype wire
